// >>> shared/panel_keys_pkg.sv
// Package of constants and types for the front-panel key and infrared port block.
package panel_keys_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned IR_ACTIVE_MINUTES = 4;
  localparam longint unsigned IR_ACTIVE_CYCLES = longint'(IR_ACTIVE_MINUTES) * 64'd60 * longint'(CLOCK_HZ);
  localparam int unsigned SP_REPEAT_MS = 500;
  localparam int unsigned SP_REPEAT_CYCLES = (SP_REPEAT_MS * (CLOCK_HZ / 1000));

  // ----------------------------------------
  // Counts and reset values
  // ----------------------------------------
  localparam int unsigned GROUP_COUNT = 16;
  localparam int unsigned FUNC_COUNT = 32;
  localparam int unsigned PARAM_COUNT = 8;
  localparam int unsigned SETPOINT_COUNT = 4;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [15:0] VALUE_MAX = 16'hFFFF;
  localparam logic [2:0] PARAM_OUTPUT = 3'h1;

  // Lower display content kinds.
  typedef enum logic [1:0] {
    SHOW_SETPOINT = 2'b00,
    SHOW_OUTPUT_PCT = 2'b01,
    SHOW_MOTOR_EST = 2'b10,
    SHOW_PARAM = 2'b11
  } lower_view_type;

  // Operating states of the panel.
  typedef enum logic [1:0] {
    ST_OPERATE = 2'b00,
    ST_GROUP_SELECT = 2'b01,
    ST_FUNCTION = 2'b10,
    ST_CALIBRATE = 2'b11
  } panel_state_type;

  // One-cycle key press pulses from the keypad.
  typedef struct packed {
    logic setup;
    logic function_key;
    logic lower_display;
    logic hand_auto;
    logic setpoint_choice_key;
    logic run_hold;
    logic acknowledge;
    logic up;
    logic down;
  } key_press_type;

endpackage

// >>> hw/ir_port_gate.sv
// Infrared port activity gate with idle shutdown timer.
`timescale 1ns/100ps
`default_nettype none
module ir_port_gate #(
  parameter longint unsigned ACTIVE_CYCLES = panel_keys_pkg::IR_ACTIVE_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic any_key,
  input wire logic infrared_port_permit,
  output logic port_active
);

  // The default four-minute period needs 33 bits; a 32-bit timer would wrap it short.
  logic [32:0] timer_r;
  logic [32:0] timer_nxt;
  logic active_r;
  logic active_nxt;

  // ----------------------------------------
  // Timer next state
  // ----------------------------------------
  // A press with the permit cleared never opens the port, so the refusal holds.
  always_comb begin
    timer_nxt = timer_r;
    active_nxt = active_r;
    if (!infrared_port_permit) begin
      active_nxt = 1'b0;
      timer_nxt = 33'h0_0000_0000;
    end else if (any_key) begin
      active_nxt = 1'b1;
      timer_nxt = ACTIVE_CYCLES[32:0] - 33'h0_0000_0001;
    end else if (active_r) begin
      if (timer_r == 33'h0_0000_0000) begin
        active_nxt = 1'b0;
      end else begin
        timer_nxt = timer_r - 33'h0_0000_0001;
      end
    end
  end

  // Registers; port starts inactive.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_r <= 33'h0_0000_0000;
      active_r <= 1'b0;
    end else begin
      timer_r <= timer_nxt;
      active_r <= active_nxt;
    end
  end

  assign port_active = active_r;

  a_ir_refused: assert property (@(posedge clock) disable iff (!resetn) !infrared_port_permit |=> !active_r)
    else $error("Infrared port active without permit.");
  a_ir_wake: assert property (@(posedge clock) disable iff (!resetn)
    (any_key && infrared_port_permit) |=> (active_r && timer_r == ACTIVE_CYCLES[32:0] - 33'h0_0000_0001))
    else $error("Key press did not open port with full timer.");
  a_ir_timeout: assert property (@(posedge clock) disable iff (!resetn)
    (active_r && timer_r == 33'h0_0000_0000 && !any_key) |=> !active_r)
    else $error("Infrared port did not shut down at timeout.");

endmodule
`default_nettype wire

// >>> hw/panel_keys.sv
// Front-panel key handler: set-up navigation, display selection, modes and values.
`timescale 1ns/100ps
`default_nettype none
module panel_keys #(
  parameter longint unsigned IR_CYCLES = panel_keys_pkg::IR_ACTIVE_CYCLES,
  parameter int unsigned SP_CYCLES = panel_keys_pkg::SP_REPEAT_CYCLES,
  parameter int unsigned GROUPS = panel_keys_pkg::GROUP_COUNT,
  parameter int unsigned FUNCS = panel_keys_pkg::FUNC_COUNT,
  parameter int unsigned PARAMS = panel_keys_pkg::PARAM_COUNT,
  parameter int unsigned SETPOINTS = panel_keys_pkg::SETPOINT_COUNT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire panel_keys_pkg::key_press_type key_press,
  input wire logic setpoint_key_held,
  input wire logic calibration_mode,
  input wire logic limit_variant,
  input wire logic step_no_slidewire,
  input wire logic param_is_set_choice,
  input wire logic infrared_port_permit,
  input wire logic alarm1_latched,
  input wire logic diag_pending,
  output logic hand_operation,
  output panel_keys_pkg::panel_state_type panel_state,
  output logic [3:0] group_index,
  output logic [4:0] function_index,
  output logic [2:0] param_index,
  output logic [1:0] setpoint_index,
  output panel_keys_pkg::lower_view_type lower_view,
  output logic [15:0] value,
  output logic ramp_running,
  output logic limit_relay_clear,
  output logic alarm1_clear,
  output logic diag_ack,
  output logic cal_step,
  output logic ir_port_active
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  panel_keys_pkg::panel_state_type state_r, state_nxt;
  logic hand_r, hand_nxt;
  logic [3:0] group_r, group_nxt;
  logic [4:0] func_r, func_nxt;
  logic [2:0] param_r, param_nxt;
  logic [1:0] sp_r, sp_nxt;
  logic [15:0] value_r, value_nxt;
  logic ramp_r, ramp_nxt;
  logic relay_clr_r, relay_clr_nxt;
  logic alarm_clr_r, alarm_clr_nxt;
  logic diag_r, diag_nxt;
  logic cal_r, cal_nxt;
  logic [31:0] sp_timer_r, sp_timer_nxt;
  panel_keys_pkg::lower_view_type view_r, view_nxt;
  logic any_key;
  logic edit_ok;

  // Wraps an index at its configured count.
  function automatic logic [7:0] step_wrap(input logic [7:0] idx, input int unsigned count);
    if (32'(idx) + 1 >= count) begin
      step_wrap = 8'h00;
    end else begin
      step_wrap = idx + 8'h01;
    end
  endfunction

  assign any_key = |key_press;

  // The output is locked in automatic mode; other parameters stay editable.
  assign edit_ok = (param_r != panel_keys_pkg::PARAM_OUTPUT) || hand_r;

  // ----------------------------------------
  // Navigation, mode and value next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    hand_nxt = hand_r;
    group_nxt = group_r;
    func_nxt = func_r;
    param_nxt = param_r;
    sp_nxt = sp_r;
    value_nxt = value_r;
    ramp_nxt = ramp_r;
    relay_clr_nxt = 1'b0;
    alarm_clr_nxt = 1'b0;
    diag_nxt = 1'b0;
    cal_nxt = 1'b0;
    sp_timer_nxt = sp_timer_r;
    // Set-up key: first press enters group selection, later ones step groups.
    if (key_press.setup) begin
      if (state_r == panel_keys_pkg::ST_GROUP_SELECT || state_r == panel_keys_pkg::ST_FUNCTION) begin
        group_nxt = 4'(step_wrap({4'h0, group_r}, GROUPS));
      end else begin
        group_nxt = 4'h0;
      end
      state_nxt = panel_keys_pkg::ST_GROUP_SELECT;
      func_nxt = 5'h00;
    end else if (key_press.function_key) begin
      if (calibration_mode) begin
        state_nxt = panel_keys_pkg::ST_CALIBRATE;
        cal_nxt = 1'b1;
      end else if (state_r == panel_keys_pkg::ST_GROUP_SELECT) begin
        state_nxt = panel_keys_pkg::ST_FUNCTION;
        func_nxt = 5'h00;
      end else if (state_r == panel_keys_pkg::ST_FUNCTION) begin
        func_nxt = 5'(step_wrap({3'h0, func_r}, FUNCS));
      end
    end
    // Lower-display key leaves set-up and steps the shown parameter.
    if (key_press.lower_display) begin
      state_nxt = panel_keys_pkg::ST_OPERATE;
      param_nxt = 3'(step_wrap({5'h00, param_r}, PARAMS));
    end
    // Manual/auto key toggles the mode; on limit variants it resets the relay instead.
    if (key_press.hand_auto) begin
      if (limit_variant) begin
        relay_clr_nxt = 1'b1;
      end else begin
        hand_nxt = !hand_r;
      end
    end
    // Holding the key repeats at a fixed rate so each setpoint can be read.
    if (key_press.setpoint_choice_key) begin
      sp_nxt = 2'(step_wrap({6'h00, sp_r}, SETPOINTS));
      sp_timer_nxt = SP_CYCLES - 1;
    end else if (setpoint_key_held) begin
      if (sp_timer_r == 32'h0000_0000) begin
        sp_nxt = 2'(step_wrap({6'h00, sp_r}, SETPOINTS));
        sp_timer_nxt = SP_CYCLES - 1;
      end else begin
        sp_timer_nxt = sp_timer_r - 32'h0000_0001;
      end
    end
    if (key_press.run_hold) begin
      ramp_nxt = !ramp_r;
    end
    // Acknowledge pulses go out only when something is pending.
    if (key_press.acknowledge) begin
      alarm_clr_nxt = alarm1_latched;
      diag_nxt = diag_pending;
    end
    // Up and down saturate; pressing both at once changes nothing.
    if (edit_ok && (state_r == panel_keys_pkg::ST_OPERATE || param_is_set_choice)) begin
      if (key_press.up && !key_press.down && value_r != panel_keys_pkg::VALUE_MAX) begin
        value_nxt = value_r + 16'h0001;
      end else if (key_press.down && !key_press.up && value_r != 16'h0000) begin
        value_nxt = value_r - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Lower display content
  // ----------------------------------------
  always_comb begin
    if (param_nxt != panel_keys_pkg::PARAM_OUTPUT && param_nxt != 3'h0) begin
      view_nxt = panel_keys_pkg::SHOW_PARAM;
    end else if (!hand_nxt) begin
      view_nxt = panel_keys_pkg::SHOW_SETPOINT;
    end else if (step_no_slidewire) begin
      view_nxt = panel_keys_pkg::SHOW_MOTOR_EST;
    end else begin
      view_nxt = panel_keys_pkg::SHOW_OUTPUT_PCT;
    end
  end

  // Registers for all panel state.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= panel_keys_pkg::ST_OPERATE;
      hand_r <= 1'b0;
      group_r <= 4'h0;
      func_r <= 5'h00;
      param_r <= 3'h0;
      sp_r <= 2'h0;
      value_r <= panel_keys_pkg::VALUE_RESET;
      ramp_r <= 1'b0;
      relay_clr_r <= 1'b0;
      alarm_clr_r <= 1'b0;
      diag_r <= 1'b0;
      cal_r <= 1'b0;
      sp_timer_r <= 32'h0000_0000;
      view_r <= panel_keys_pkg::SHOW_SETPOINT;
    end else begin
      state_r <= state_nxt;
      hand_r <= hand_nxt;
      group_r <= group_nxt;
      func_r <= func_nxt;
      param_r <= param_nxt;
      sp_r <= sp_nxt;
      value_r <= value_nxt;
      ramp_r <= ramp_nxt;
      relay_clr_r <= relay_clr_nxt;
      alarm_clr_r <= alarm_clr_nxt;
      diag_r <= diag_nxt;
      cal_r <= cal_nxt;
      sp_timer_r <= sp_timer_nxt;
      view_r <= view_nxt;
    end
  end

  // ----------------------------------------
  // Infrared gate
  // ----------------------------------------
  ir_port_gate #(
    .ACTIVE_CYCLES(IR_CYCLES)
  ) u_ir (
    .clock(clock),
    .resetn(resetn),
    .any_key(any_key),
    .infrared_port_permit(infrared_port_permit),
    .port_active(ir_port_active)
  );

  assign hand_operation = hand_r;
  assign panel_state = state_r;
  assign group_index = group_r;
  assign function_index = func_r;
  assign param_index = param_r;
  assign setpoint_index = sp_r;
  assign lower_view = view_r;
  assign value = value_r;
  assign ramp_running = ramp_r;
  assign limit_relay_clear = relay_clr_r;
  assign alarm1_clear = alarm_clr_r;
  assign diag_ack = diag_r;
  assign cal_step = cal_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_setup_enter: assert property (@(posedge clock) disable iff (!resetn)
    (key_press.setup && !key_press.lower_display) |=> state_r == panel_keys_pkg::ST_GROUP_SELECT)
    else $error("Set-up key did not enter group selection.");
  a_group_step: assert property (@(posedge clock) disable iff (!resetn)
    (key_press.setup && state_r == panel_keys_pkg::ST_GROUP_SELECT && group_r == 4'h0) |=> group_r == 4'h1)
    else $error("Group did not step.");
  a_cal_step: assert property (@(posedge clock) disable iff (!resetn)
    (key_press.function_key && !key_press.setup && calibration_mode) |=> cal_step ##1 !cal_step)
    else $error("Calibration step pulse wrong.");
  a_mode_toggle: assert property (@(posedge clock) disable iff (!resetn)
    (key_press.hand_auto && !limit_variant) |=> hand_r != $past(hand_r))
    else $error("Manual/auto key did not toggle.");
  a_auto_view: assert property (@(posedge clock) disable iff (!resetn)
    (!hand_r && param_r == 3'h0) |-> lower_view == panel_keys_pkg::SHOW_SETPOINT)
    else $error("Automatic mode not showing setpoint.");
  a_relay_reset: assert property (@(posedge clock) disable iff (!resetn)
    (key_press.hand_auto && limit_variant) |=> limit_relay_clear && $stable(hand_r))
    else $error("Limit relay reset misbehaved.");
  a_ramp_toggle: assert property (@(posedge clock) disable iff (!resetn)
    key_press.run_hold |=> ramp_running != $past(ramp_running))
    else $error("Run/hold did not toggle.");
  a_alarm_ack: assert property (@(posedge clock) disable iff (!resetn)
    (key_press.acknowledge && alarm1_latched) |=> alarm1_clear ##1 !alarm1_clear)
    else $error("Alarm 1 acknowledge pulse wrong.");
  a_output_lock: assert property (@(posedge clock) disable iff (!resetn)
    (!hand_r && param_r == panel_keys_pkg::PARAM_OUTPUT) |=> value_r == $past(value_r))
    else $error("Output changed in automatic mode.");

endmodule
`default_nettype wire

// >>> tb/operator_keypad.sv
// Operator keypad model: one-cycle key press pulses and the held setpoint choice key.
`timescale 1ns/100ps
`default_nettype none
module operator_keypad (
  input wire logic clock,
  output panel_keys_pkg::key_press_type key_press,
  output logic setpoint_key_held
);
  // --------------------------------
  // Idle keypad at time zero
  // --------------------------------
  initial begin
    key_press = '0;
    setpoint_key_held = 1'b0;
  end

  // A press is launched on a falling edge and lasts one cycle, so the block samples it exactly once.
  // A real operator could bounce a key; debouncing is not modelled here.
  task automatic press(input logic [8:0] keys);
    @(negedge clock);
    key_press = keys;
    @(negedge clock);
    key_press = '0;
    @(negedge clock);
  endtask

  // Press and start holding together, as a finger does; a level raised earlier would step on its own first.
  task automatic press_hold(input logic [8:0] keys);
    @(negedge clock);
    key_press = keys;
    setpoint_key_held = 1'b1;
    @(negedge clock);
    key_press = '0;
  endtask

  // The setpoint choice key level changes only on a falling edge.
  task automatic hold(input logic level);
    @(negedge clock);
    setpoint_key_held = level;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the front-panel key and infrared port block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  // --------------------------------
  // Shortened counts and key codes
  // --------------------------------
  localparam longint unsigned IR_CYC = 20;
  localparam int unsigned SP_CYC = 4;
  localparam logic [8:0] K_SETUP = 9'h100;
  localparam logic [8:0] K_FUNC = 9'h080;
  localparam logic [8:0] K_LOW = 9'h040;
  localparam logic [8:0] K_HA = 9'h020;
  localparam logic [8:0] K_SP = 9'h010;
  localparam logic [8:0] K_RUN = 9'h008;
  localparam logic [8:0] K_ACK = 9'h004;
  localparam logic [8:0] K_UP = 9'h002;
  localparam logic [8:0] K_DOWN = 9'h001;

  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic calibration_mode, limit_variant, step_no_slidewire, param_is_set_choice;
  logic infrared_port_permit, alarm1_latched, diag_pending, setpoint_key_held;
  panel_keys_pkg::key_press_type key_press;
  panel_keys_pkg::panel_state_type panel_state;
  panel_keys_pkg::lower_view_type lower_view;
  logic hand_operation, ramp_running, limit_relay_clear, alarm1_clear, diag_ack, cal_step, ir_port_active;
  logic [3:0] group_index;
  logic [4:0] function_index;
  logic [2:0] param_index;
  logic [1:0] setpoint_index;
  logic [15:0] value;
  int miscompares = 0;
  int samples_checked = 0;
  int n_pulse[4] = '{default: 0};

  always #25 clock = ~clock;

  operator_keypad operator_keypad_inst (.clock(clock), .key_press(key_press), .setpoint_key_held(setpoint_key_held));

  panel_keys #(.IR_CYCLES(IR_CYC), .SP_CYCLES(SP_CYC)) panel_keys_inst (
    .clock(clock), .resetn(resetn), .key_press(key_press), .setpoint_key_held(setpoint_key_held),
    .calibration_mode(calibration_mode), .limit_variant(limit_variant), .step_no_slidewire(step_no_slidewire),
    .param_is_set_choice(param_is_set_choice), .infrared_port_permit(infrared_port_permit),
    .alarm1_latched(alarm1_latched), .diag_pending(diag_pending), .hand_operation(hand_operation),
    .panel_state(panel_state), .group_index(group_index), .function_index(function_index),
    .param_index(param_index), .setpoint_index(setpoint_index), .lower_view(lower_view), .value(value),
    .ramp_running(ramp_running), .limit_relay_clear(limit_relay_clear), .alarm1_clear(alarm1_clear),
    .diag_ack(diag_ack), .cal_step(cal_step), .ir_port_active(ir_port_active)
  );

  // Count cycles each strobe is high; a count of one proves both presence and one-cycle width.
  always @(posedge clock) begin
    n_pulse[0] <= n_pulse[0] + int'(limit_relay_clear);
    n_pulse[1] <= n_pulse[1] + int'(alarm1_clear);
    n_pulse[2] <= n_pulse[2] + int'(diag_ack);
    n_pulse[3] <= n_pulse[3] + int'(cal_step);
  end

  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks made %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic press(input logic [8:0] keys);
    operator_keypad_inst.press(keys);
  endtask

  // Reset with every level input in a known state; permit is left high so presses open the port.
  task automatic do_reset;
    resetn = 1'b0;
    calibration_mode = 1'b0;
    limit_variant = 1'b0;
    step_no_slidewire = 1'b0;
    param_is_set_choice = 1'b0;
    infrared_port_permit = 1'b1;
    alarm1_latched = 1'b0;
    diag_pending = 1'b0;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    n_pulse = '{default: 0};
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_navigate;
    do_reset();
    check(16'(ir_port_active), 16'h0000);
    press(K_SETUP);
    check(16'(panel_state), 16'(panel_keys_pkg::ST_GROUP_SELECT));
    check(16'(group_index), 16'h0000);
    press(K_SETUP);
    check(16'(group_index), 16'h0001);
    press(K_FUNC);
    check(16'(panel_state), 16'(panel_keys_pkg::ST_FUNCTION));
    press(K_FUNC);
    check(16'(function_index), 16'h0001);
    do_reset();
    calibration_mode = 1'b1;
    press(K_FUNC);
    repeat (2) @(negedge clock);
    check(16'(n_pulse[3]), 16'h0001);
    $display("navigate test done");
  endtask

  task automatic t_display_mode;
    do_reset();
    press(K_LOW);
    check(16'(param_index), 16'h0001);
    press(K_LOW);
    check(16'(param_index), 16'h0002);
    check(16'(lower_view), 16'(panel_keys_pkg::SHOW_PARAM));
    do_reset();
    press(K_HA);
    check(16'(hand_operation), 16'h0001);
    check(16'(lower_view), 16'(panel_keys_pkg::SHOW_OUTPUT_PCT));
    step_no_slidewire = 1'b1;
    press(K_HA);
    check(16'(hand_operation), 16'h0000);
    check(16'(lower_view), 16'(panel_keys_pkg::SHOW_SETPOINT));
    press(K_HA);
    check(16'(lower_view), 16'(panel_keys_pkg::SHOW_MOTOR_EST));
    do_reset();
    limit_variant = 1'b1;
    press(K_HA);
    repeat (2) @(negedge clock);
    check(16'(n_pulse[0]), 16'h0001);
    check(16'(hand_operation), 16'h0000);
    $display("display and mode test done");
  endtask

  task automatic t_setpoint_ramp_ack;
    do_reset();
    operator_keypad_inst.press_hold(K_SP);
    check(16'(setpoint_index), 16'h0001);
    repeat (SP_CYC) @(negedge clock);
    check(16'(setpoint_index), 16'h0002);
    operator_keypad_inst.hold(1'b0);
    press(K_RUN);
    check(16'(ramp_running), 16'h0001);
    press(K_RUN);
    check(16'(ramp_running), 16'h0000);
    alarm1_latched = 1'b1;
    diag_pending = 1'b1;
    press(K_ACK);
    alarm1_latched = 1'b0;
    diag_pending = 1'b0;
    press(K_ACK);
    repeat (2) @(negedge clock);
    check(16'(n_pulse[1]), 16'h0001);
    check(16'(n_pulse[2]), 16'h0001);
    $display("setpoint, ramp and acknowledge test done");
  endtask

  task automatic t_values;
    do_reset();
    press(K_UP);
    check(value, 16'h0001);
    press(K_DOWN);
    check(value, 16'h0000);
    press(K_DOWN);
    check(value, 16'h0000);
    press(K_LOW);
    press(K_UP);
    check(value, 16'h0000);
    press(K_HA);
    press(K_UP);
    check(value, 16'h0001);
    do_reset();
    press(K_SETUP);
    press(K_UP);
    check(value, 16'h0000);
    param_is_set_choice = 1'b1;
    press(K_UP);
    check(value, 16'h0001);
    $display("value edit test done");
  endtask

  task automatic t_infrared;
    do_reset();
    press(K_RUN);
    check(16'(ir_port_active), 16'h0001);
    repeat (10) @(negedge clock);
    press(K_RUN);
    repeat (16) @(negedge clock);
    check(16'(ir_port_active), 16'h0001);
    for (int i = 0; i < 8 && ir_port_active !== 1'b0; i++) begin
      @(negedge clock);
    end
    check(16'(ir_port_active), 16'h0000);
    if (ir_port_active !== 1'b0) begin
      tally_and_finish();
    end
    infrared_port_permit = 1'b0;
    press(K_RUN);
    check(16'(ir_port_active), 16'h0000);
    $display("infrared port test done");
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    t_navigate();
    t_display_mode();
    t_setpoint_ramp_ack();
    t_values();
    t_infrared();
    tally_and_finish();
  end
endmodule
`default_nettype wire
